/* File: modbus_regs_consts.svh */
`ifndef MODBUS_REGS_CONSTS_SVH
`define MODBUS_REGS_CONSTS_SVH
// register addresses (zero-based pdu addresses)
`define ADDR_MEASURE_LOW 16'h0000
`define ADDR_MEASURE_HIGH 16'h0001
`define ADDR_PROTOCOL 16'h0604
`define ADDR_RESTART 16'h0605
`define ADDR_TEST_INT 16'h1f00
`define ADDR_TEST_FLOAT_LOW 16'h1f01
`define ADDR_TEST_FLOAT_HIGH 16'h1f02
`define ADDR_TEST_TEXT0 16'h1f03
`define ADDR_TEST_TEXT1 16'h1f04
`define ADDR_TEST_TEXT2 16'h1f05
`define ADDR_TEST_TEXT3 16'h1f06
// constant register contents
`define TEST_INT_VALUE 16'hcfc7
`define TEST_FLOAT_LOW_VALUE 16'he666
`define TEST_FLOAT_HIGH_VALUE 16'hc2f6
`define TEST_TEXT0_VALUE 16'h2d31
`define TEST_TEXT1_VALUE 16'h3233
`define TEST_TEXT2_VALUE 16'h2e34
`define TEST_TEXT3_VALUE 16'h3500
`define QNAN_HIGH 16'h7fc0
`define QNAN_LOW 16'h0000
`define READ_AS_ZERO 16'h0000
// protocol selection codes
`define PROTO_COMMAND_LINE 16'h0000
`define PROTO_AUTOMATIC 16'h0001
`define PROTO_POLLED 16'h0002
`define PROTO_ANALOG 16'h0005
`define PROTO_MODBUS 16'h0006
`define PROTOCOL_RESET 16'h0006
`define RESTART_KEY 16'h0001
// function codes and exceptions
`define FC_READ_HOLDING 8'h03
`define FC_WRITE_MULTIPLE 8'h10
`define FC_DEVICE_ID 8'h2b
`define MEI_DEVICE_ID 8'h0e
`define FC_EXCEPTION_FLAG 8'h80
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`define EXC_ILLEGAL_VALUE 8'h03
`define READ_QTY_MAX 16'h007d
`define WRITE_QTY_MAX 16'h007b
`define ADDR_SPACE_END 17'h10000
// device identification
`define ID_CONFORMITY 8'h83
`define ID_OBJECT_LEN 8'h08
`define ID_STANDARD_LAST 8'h04
`define ID_VENDOR_FIRST 8'h80
`define ID_VENDOR_LAST 8'h82
`define ID_CODE_LAST 8'h04
// request and response lengths in bytes
`define READ_REQ_LEN 9'h005
`define WRITE_REQ_HDR_LEN 9'h006
`define ID_REQ_LEN 9'h004
`define ID_HDR_LEN 9'h009
`define ID_RESPONSE_LEN 9'h011
`define WRITE_RESPONSE_LEN 9'h005
`define EXC_RESPONSE_LEN 9'h002
`define RX_BUFFER_DEPTH 9'h100
`endif

/* File: modbus_regs_pkg.sv */
package modbus_regs_pkg;
  typedef logic [15:0] word_type;
  typedef logic [7:0] byte_type;
  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_WRITE, ST_SEND} state_type;
  typedef enum logic [1:0] {RESP_READ, RESP_WRITE, RESP_ID, RESP_EXC} resp_type;
endpackage : modbus_regs_pkg

/* File: reg_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface reg_port_if;
  logic [15:0] addr;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic snapshot;
  modport engine (output addr, output wr_en, output wr_data, output snapshot, input rd_data);
  modport bank (input addr, input wr_en, input wr_data, input snapshot, output rd_data);
endinterface : reg_port_if
`default_nettype wire

/* File: modbus_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modbus_regs_consts.svh"
module modbus_reg_bank (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // word access from the frame engine
  reg_port_if.bank regs,
  // measurement from logic on the same clock
  input wire logic [31:0] measure_value_in,
  input wire logic measure_valid_in,
  // recovery pin
  input wire logic command_line_request_in,
  // device state
  output var modbus_regs_pkg::word_type active_protocol_out,
  output logic device_restart_out
);
  import modbus_regs_pkg::*;

  word_type pending, next_pending, active, next_active;
  logic restart, next_restart;
  logic [31:0] snap, next_snap;
  logic snap_valid, next_snap_valid;
  logic ovr_meta, ovr_sync;

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      ovr_meta <= 1'b0;
      ovr_sync <= 1'b0;
    end
    else
    begin
      ovr_meta <= command_line_request_in;
      ovr_sync <= ovr_meta;
    end

  always_comb
  begin
    next_pending = pending;
    next_active = active;
    next_restart = 1'b0;
    next_snap = snap;
    next_snap_valid = snap_valid;
    // whole pair captured once per accepted read request
    if (regs.snapshot)
    begin
      next_snap = measure_value_in;
      next_snap_valid = measure_valid_in;
    end
    if (ovr_sync)
    begin
      next_pending = `PROTO_COMMAND_LINE;
      next_active = `PROTO_COMMAND_LINE;
    end
    else if (regs.wr_en)
    begin
      // any 16-bit value kept as written; read-only addresses fall through
      if (regs.addr == `ADDR_PROTOCOL)
        next_pending = regs.wr_data;
      if (regs.addr == `ADDR_RESTART && regs.wr_data == `RESTART_KEY)
      begin
        next_restart = 1'b1;
        next_active = pending;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      pending <= `PROTOCOL_RESET;
      active <= `PROTOCOL_RESET;
      restart <= 1'b0;
      snap <= 32'h0000_0000;
      snap_valid <= 1'b0;
    end
    else
    begin
      pending <= next_pending;
      active <= next_active;
      restart <= next_restart;
      snap <= next_snap;
      snap_valid <= next_snap_valid;
    end

  always_comb
  begin
    unique case (regs.addr)
      `ADDR_MEASURE_LOW: regs.rd_data = snap_valid ? snap[15:0] : `QNAN_LOW;
      `ADDR_MEASURE_HIGH: regs.rd_data = snap_valid ? snap[31:16] : `QNAN_HIGH;
      `ADDR_PROTOCOL: regs.rd_data = pending;
      `ADDR_RESTART: regs.rd_data = `READ_AS_ZERO;
      `ADDR_TEST_INT: regs.rd_data = `TEST_INT_VALUE;
      `ADDR_TEST_FLOAT_LOW: regs.rd_data = `TEST_FLOAT_LOW_VALUE;
      `ADDR_TEST_FLOAT_HIGH: regs.rd_data = `TEST_FLOAT_HIGH_VALUE;
      `ADDR_TEST_TEXT0: regs.rd_data = `TEST_TEXT0_VALUE;
      `ADDR_TEST_TEXT1: regs.rd_data = `TEST_TEXT1_VALUE;
      `ADDR_TEST_TEXT2: regs.rd_data = `TEST_TEXT2_VALUE;
      `ADDR_TEST_TEXT3: regs.rd_data = `TEST_TEXT3_VALUE;
      default: regs.rd_data = `READ_AS_ZERO;
    endcase
  end

  assign active_protocol_out = active;
  assign device_restart_out = restart;

  property p_restart_applies;
    @(posedge clk_in) disable iff (rst_in)
    (regs.wr_en && regs.addr == `ADDR_RESTART && regs.wr_data == `RESTART_KEY && !ovr_sync)
    |=> (device_restart_out && active_protocol_out == $past(pending));
  endproperty
  a_restart_applies: assert property (p_restart_applies) else $error("restart not applied");

  property p_pending_holds;
    @(posedge clk_in) disable iff (rst_in)
    (!device_restart_out && !$past(ovr_sync)) |-> $stable(active_protocol_out);
  endproperty
  a_pending_holds: assert property (p_pending_holds) else $error("active changed early");

  property p_write_only_zero;
    @(posedge clk_in) disable iff (rst_in)
    (regs.addr == `ADDR_RESTART) |-> (regs.rd_data == 16'h0000);
  endproperty
  a_write_only_zero: assert property (p_write_only_zero) else $error("write-only read nonzero");

  property p_read_only_kept;
    @(posedge clk_in) disable iff (rst_in)
    (regs.wr_en && regs.addr != `ADDR_PROTOCOL && !ovr_sync) |=> $stable(pending);
  endproperty
  a_read_only_kept: assert property (p_read_only_kept) else $error("setting changed");

  property p_nan_fill;
    @(posedge clk_in) disable iff (rst_in)
    (!snap_valid && regs.addr == `ADDR_MEASURE_HIGH) |-> (regs.rd_data == 16'h7fc0);
  endproperty
  a_nan_fill: assert property (p_nan_fill) else $error("missing quiet nan");

  property p_override;
    @(posedge clk_in) disable iff (rst_in)
    ovr_sync |=> (active_protocol_out == 16'h0000 && pending == 16'h0000);
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_pair_coherent;
    @(posedge clk_in) disable iff (rst_in)
    !regs.snapshot |=> $stable(snap);
  endproperty
  a_pair_coherent: assert property (p_pair_coherent) else $error("pair torn");
endmodule : modbus_reg_bank
`default_nettype wire

/* File: modbus_rtu_slave_register_map.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modbus_regs_consts.svh"
module modbus_rtu_slave_register_map #(
  // identification strings, seven characters and a zero byte; values arbitrary
  parameter logic [7:0][63:0] ID_OBJECTS = {
    {"CALTXT0", 8'h00}, {"CALDATE", 8'h00}, {"SERIAL0", 8'h00}, {"PROBE00", 8'h00},
    {"URL0000", 8'h00}, {"VER0000", 8'h00}, {"PART000", 8'h00}, {"MAKER00", 8'h00}}
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // request pdu bytes, one frame per request
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_last_in,
  output logic rx_ready_out,
  // response pdu bytes
  output var modbus_regs_pkg::byte_type tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  // measurement value
  input wire logic [31:0] measure_value_in,
  input wire logic measure_valid_in,
  // recovery pin
  input wire logic command_line_request_in,
  // device state
  output var modbus_regs_pkg::word_type active_protocol_out,
  output logic device_restart_out
);
  import modbus_regs_pkg::*;

  reg_port_if regs ();

  modbus_reg_bank bank (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .regs(regs.bank),
    .measure_value_in(measure_value_in),
    .measure_valid_in(measure_valid_in),
    .command_line_request_in(command_line_request_in),
    .active_protocol_out(active_protocol_out),
    .device_restart_out(device_restart_out)
  );

  state_type state, next_state;
  resp_type kind, next_kind;
  logic [8:0] rx_count, next_rx_count;
  logic overflow, next_overflow;
  logic [8:0] idx, next_idx, len, next_len;
  logic [7:0] exc_code, next_exc_code;
  logic [6:0] widx, next_widx;
  byte_type tx_data, next_tx_data;
  logic tx_valid, next_tx_valid, tx_last, next_tx_last;
  logic [7:0] req_buf [0:255];
  logic buf_we;
  logic [7:0] fc, mei, id_code, obj;
  logic [15:0] start, qty;
  logic [7:0] byte_count;
  logic range_bad, obj_ok;
  logic [2:0] obj_sel, str_pos;
  logic [8:0] word_off;
  logic [8:0] str_off;
  logic [7:0] byte_value;
  logic [7:0] wr_base;

  // request fields, straight pdu addresses with no offset
  assign fc = req_buf[0];
  assign mei = req_buf[1];
  assign id_code = req_buf[2];
  assign obj = req_buf[3];
  assign start = {req_buf[1], req_buf[2]};
  assign qty = {req_buf[3], req_buf[4]};
  assign byte_count = req_buf[5];
  assign range_bad = ({1'b0, start} + {1'b0, qty}) > `ADDR_SPACE_END;
  assign obj_ok = (obj <= `ID_STANDARD_LAST) || (obj >= `ID_VENDOR_FIRST && obj <= `ID_VENDOR_LAST);
  assign obj_sel = (obj <= `ID_STANDARD_LAST) ? obj[2:0] : obj[2:0] + 3'h5;

  assign rx_ready_out = (state == ST_IDLE);
  assign buf_we = (state == ST_IDLE) && rx_valid_in && (rx_count < `RX_BUFFER_DEPTH);

  // request buffer holds whole 8-bit characters of one frame
  always_ff @(posedge clk_in)
    if (buf_we)
      req_buf[rx_count[7:0]] <= rx_data_in;

  // word access towards the bank
  assign word_off = (idx - 9'h002) >> 1;
  assign wr_base = 8'h06 + {widx, 1'b0};
  assign regs.addr = (state == ST_WRITE) ? start + {9'h000, widx} : start + {7'h00, word_off};
  assign regs.wr_en = (state == ST_WRITE);
  assign regs.wr_data = {req_buf[wr_base], req_buf[wr_base + 8'h01]};
  assign regs.snapshot = (state == ST_EXEC) && (next_kind == RESP_READ);

  // response byte for the current index
  assign str_off = idx - `ID_HDR_LEN;
  assign str_pos = str_off[2:0];
  always_comb
  begin
    byte_value = 8'h00;
    unique case (kind)
      RESP_READ:
        if (idx == 9'h000)
          byte_value = fc;
        else if (idx == 9'h001)
          byte_value = {qty[6:0], 1'b0};
        else if (idx[0] == 1'b0)
          byte_value = regs.rd_data[15:8];
        else
          byte_value = regs.rd_data[7:0];
      RESP_WRITE:
        if (idx == 9'h000)
          byte_value = fc;
        else
          byte_value = req_buf[idx[7:0]];
      RESP_ID:
        unique case (idx)
          9'h000: byte_value = fc;
          9'h001: byte_value = mei;
          9'h002: byte_value = id_code;
          9'h003: byte_value = `ID_CONFORMITY;
          9'h004: byte_value = 8'h00;
          9'h005: byte_value = 8'h00;
          9'h006: byte_value = 8'h01;
          9'h007: byte_value = obj;
          9'h008: byte_value = `ID_OBJECT_LEN;
          default: byte_value = ID_OBJECTS[obj_sel][8 * (7 - str_pos) +: 8];
        endcase
      RESP_EXC:
        byte_value = (idx == 9'h000) ? (fc | `FC_EXCEPTION_FLAG) : exc_code;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_kind = kind;
    next_rx_count = rx_count;
    next_overflow = overflow;
    next_idx = idx;
    next_len = len;
    next_exc_code = exc_code;
    next_widx = widx;
    next_tx_data = tx_data;
    next_tx_valid = tx_valid;
    next_tx_last = tx_last;
    unique case (state)
      ST_IDLE:
        if (rx_valid_in)
        begin
          if (rx_count < `RX_BUFFER_DEPTH)
            next_rx_count = rx_count + 9'h001;
          else
            next_overflow = 1'b1;
          if (rx_last_in)
            next_state = ST_EXEC;
        end
      ST_EXEC:
      begin
        next_rx_count = 9'h000;
        next_overflow = 1'b0;
        next_idx = 9'h000;
        next_widx = 7'h00;
        next_kind = RESP_EXC;
        next_len = `EXC_RESPONSE_LEN;
        next_state = ST_SEND;
        next_exc_code = `EXC_ILLEGAL_FUNCTION;
        if (overflow)
          next_state = ST_IDLE;
        else if (fc == `FC_READ_HOLDING)
        begin
          if (rx_count != `READ_REQ_LEN || qty == 16'h0000 || qty > `READ_QTY_MAX)
            next_exc_code = `EXC_ILLEGAL_VALUE;
          else if (range_bad)
            next_exc_code = `EXC_ILLEGAL_ADDRESS;
          else
          begin
            // gaps inside the range are served, not refused
            next_kind = RESP_READ;
            next_len = {qty[7:0], 1'b0} + 9'h002;
          end
        end
        else if (fc == `FC_WRITE_MULTIPLE)
        begin
          if (qty == 16'h0000 || qty > `WRITE_QTY_MAX || byte_count != {qty[6:0], 1'b0}
              || rx_count != `WRITE_REQ_HDR_LEN + {qty[7:0], 1'b0})
            next_exc_code = `EXC_ILLEGAL_VALUE;
          else if (range_bad)
            next_exc_code = `EXC_ILLEGAL_ADDRESS;
          else
          begin
            next_kind = RESP_WRITE;
            next_len = `WRITE_RESPONSE_LEN;
            next_state = ST_WRITE;
          end
        end
        else if (fc == `FC_DEVICE_ID && mei == `MEI_DEVICE_ID)
        begin
          if (rx_count != `ID_REQ_LEN || id_code == 8'h00 || id_code > `ID_CODE_LAST)
            next_exc_code = `EXC_ILLEGAL_VALUE;
          else if (!obj_ok)
            next_exc_code = `EXC_ILLEGAL_ADDRESS;
          else
          begin
            next_kind = RESP_ID;
            next_len = `ID_RESPONSE_LEN;
          end
        end
      end
      ST_WRITE:
      begin
        // one word per cycle, pair halves written back to back
        next_widx = widx + 7'h01;
        if ({9'h000, widx} == qty - 16'h0001)
          next_state = ST_SEND;
      end
      ST_SEND:
        if (!tx_valid || tx_ready_in)
        begin
          if (idx == len)
          begin
            next_tx_valid = 1'b0;
            next_tx_last = 1'b0;
            next_state = ST_IDLE;
          end
          else
          begin
            next_tx_data = byte_value;
            next_tx_valid = 1'b1;
            next_tx_last = (idx == len - 9'h001);
            next_idx = idx + 9'h001;
          end
        end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      state <= ST_IDLE;
      kind <= RESP_EXC;
      rx_count <= 9'h000;
      overflow <= 1'b0;
      idx <= 9'h000;
      len <= 9'h000;
      exc_code <= 8'h00;
      widx <= 7'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end
    else
    begin
      state <= next_state;
      kind <= next_kind;
      rx_count <= next_rx_count;
      overflow <= next_overflow;
      idx <= next_idx;
      len <= next_len;
      exc_code <= next_exc_code;
      widx <= next_widx;
      tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;
      tx_last <= next_tx_last;
    end

  assign tx_data_out = tx_data;
  assign tx_valid_out = tx_valid;
  assign tx_last_out = tx_last;

  sequence s_bad_function;
    (state == ST_EXEC) && !overflow && fc != 8'h03 && fc != 8'h10 && fc != 8'h2b;
  endsequence
  sequence s_exception_out;
    ##1 (tx_valid_out && tx_data_out == (fc | 8'h80));
  endsequence
  property p_bad_function;
    @(posedge clk_in) disable iff (rst_in)
    s_bad_function |=> s_exception_out;
  endproperty
  a_bad_function: assert property (p_bad_function) else $error("no illegal function answer");

  sequence s_read_ok;
    (state == ST_EXEC) && !overflow && next_kind == RESP_READ;
  endsequence
  property p_read_header;
    @(posedge clk_in) disable iff (rst_in)
    s_read_ok |=> ##1 (tx_valid_out && tx_data_out == 8'h03);
  endproperty
  a_read_header: assert property (p_read_header) else $error("read answer missing");

  property p_write_steps;
    @(posedge clk_in) disable iff (rst_in)
    (state == ST_EXEC && next_state == ST_WRITE && qty == 16'h0002)
    |=> (regs.wr_en && regs.addr == start) ##1 (regs.wr_en && regs.addr == start + 16'h0001)
    ##1 !regs.wr_en;
  endproperty
  a_write_steps: assert property (p_write_steps) else $error("pair write broken");

  property p_last_byte;
    @(posedge clk_in) disable iff (rst_in)
    (tx_valid_out && tx_last_out) |-> (idx == len);
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("last flag misplaced");
endmodule : modbus_rtu_slave_register_map
`default_nettype wire

/* File: modbus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  // clock
  input wire logic clk_in,
  // requests to the device
  output logic [7:0] req_data_out,
  output logic req_valid_out,
  output logic req_last_out,
  input wire logic req_ready_in,
  // answers from the device
  input wire logic [7:0] resp_data_in,
  input wire logic resp_valid_in,
  input wire logic resp_last_in,
  output logic resp_ready_out
);
  logic slow = 1'b0;
  logic timed_out = 1'b0;
  initial
  begin
    req_data_out = 8'h5a;
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    resp_ready_out = 1'b0;
  end
  // whole frame of 8-bit characters, then the whole answer
  // line framing, e.g. even_parity_one_stop, is done by the uart ahead
  task automatic transact(input logic [7:0] req[$], output logic [7:0] resp[$]);
    int n;
    logic done;
    resp = {};
    foreach (req[i])
    begin
      @(negedge clk_in);
      req_data_out = req[i];
      req_valid_out = 1'b1;
      req_last_out = (i == req.size() - 1);
      n = 0;
      // ready only moves at rising edges
      while (req_ready_in !== 1'b1 && n < 100)
      begin
        @(negedge clk_in);
        n++;
      end
      timed_out |= (n >= 100);
    end
    @(negedge clk_in);
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    // released line shows no stale byte
    req_data_out = ~req_data_out;
    done = 1'b0;
    n = 0;
    while (!done && n < 400)
    begin
      resp_ready_out = slow ? ~resp_ready_out : 1'b1;
      if (resp_ready_out && resp_valid_in === 1'b1)
      begin
        resp.push_back(resp_data_in);
        done = (resp_last_in === 1'b1);
      end
      @(negedge clk_in);
      n++;
    end
    resp_ready_out = 1'b0;
    timed_out |= !done;
  endtask : transact
endmodule : modbus_master_model
`default_nettype wire

/* File: modbus_rtu_slave_register_map_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "modbus_regs_consts.svh"
module modbus_rtu_slave_register_map_tb_top;
  import modbus_regs_pkg::*;
  // object strings, values arbitrary
  localparam logic [7:0][63:0] ID_TEXT = {{"OBJECT7", 8'h00}, {"OBJECT6", 8'h00},
    {"OBJECT5", 8'h00}, {"OBJECT4", 8'h00}, {"OBJECT3", 8'h00}, {"OBJECT2", 8'h00},
    {"OBJECT1", 8'h00}, {"OBJECT0", 8'h00}};
  localparam logic [63:0] TEXT = {"-123.45", 8'h00};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, restart;
  byte_type rx_data, tx_data;
  logic [31:0] measure = 32'h42f6e666;
  logic measure_ok = 1'b1;
  logic cmd_req = 1'b0;
  word_type protocol;
  int fail_count = 0;
  int cmp_count = 0;
  int pulses = 0;
  byte_type rsp[$];
  word_type w[$];
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
    if (restart === 1'b1)
      pulses++;
  modbus_rtu_slave_register_map #(.ID_OBJECTS(ID_TEXT)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_last_in(rx_last), .rx_ready_out(rx_ready), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_last_out(tx_last), .tx_ready_in(tx_ready),
    .measure_value_in(measure), .measure_valid_in(measure_ok),
    .command_line_request_in(cmd_req), .active_protocol_out(protocol),
    .device_restart_out(restart));
  modbus_master_model master_u (
    .clk_in(clk_in), .req_data_out(rx_data), .req_valid_out(rx_valid),
    .req_last_out(rx_last), .req_ready_in(rx_ready), .resp_data_in(tx_data),
    .resp_valid_in(tx_valid), .resp_last_in(tx_last), .resp_ready_out(tx_ready));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic xfer(input byte_type req[$]);
    master_u.transact(req, rsp);
    if (master_u.timed_out)
    begin
      fail_count++;
      give_verdict();
    end
  endtask : xfer
  task automatic rd(input word_type a, input byte_type q);
    xfer({`FC_READ_HOLDING, a[15:8], a[7:0], 8'h00, q});
    check("rd head", {rsp[0], rsp[1]}, {`FC_READ_HOLDING, q << 1});
    w = {};
    for (int i = 0; i < q; i++)
      w.push_back({rsp[2 + 2 * i], rsp[3 + 2 * i]});
  endtask : rd
  task automatic wr(input word_type a, input word_type v);
    xfer({`FC_WRITE_MULTIPLE, a[15:8], a[7:0], 8'h00, 8'h01, 8'h02, v[15:8], v[7:0]});
    check("wr echo", {rsp[1], rsp[2]}, a);
  endtask : wr
  task automatic t_consts();
    wr(`ADDR_TEST_INT, 16'h1234);
    wr(`ADDR_TEST_FLOAT_HIGH, 16'h0000);
    rd(`ADDR_TEST_INT, 8'h07);
    check("int", w[0], 16'(-12345));
    check("flt lo", w[1], 16'he666);
    check("flt hi", w[2], 16'hc2f6);
    for (int i = 0; i < 4; i++)
      check("text", w[3 + i], TEXT[63 - 16 * i -: 16]);
  endtask : t_consts
  task automatic t_measure();
    rd(16'h0000, 8'h02);
    check("meas", {w[1], w[0]} == measure, 16'h0001);
    measure_ok = 1'b0;
    rd(16'h0000, 8'h02);
    check("nan lo", w[0], 16'h0000);
    check("nan hi", w[1], 16'h7fc0);
    measure_ok = 1'b1;
  endtask : t_measure
  task automatic t_protocol();
    word_type codes[4] = '{`PROTO_AUTOMATIC, `PROTO_POLLED, `PROTO_ANALOG, `PROTO_MODBUS};
    int n;
    wr(`ADDR_PROTOCOL, `PROTO_COMMAND_LINE);
    rd(16'h0603, 8'h04);
    check("gap", w[0] | w[3], 16'h0000);
    check("pending", w[1], `PROTO_COMMAND_LINE);
    check("wo read", w[2], 16'h0000);
    check("held", protocol, `PROTO_MODBUS);
    n = pulses;
    wr(`ADDR_RESTART, 16'h0002);
    check("no restart", 16'(pulses - n), 16'h0000);
    wr(`ADDR_RESTART, `RESTART_KEY);
    check("restart", 16'(pulses - n), 16'h0001);
    check("applied", protocol, `PROTO_COMMAND_LINE);
    // setting and restart as one two-register write
    xfer({`FC_WRITE_MULTIPLE, 8'h06, 8'h04, 8'h00, 8'h02, 8'h04, codes[1][15:8], codes[1][7:0],
      8'h00, 8'h01});
    check("pair qty", {rsp[3], rsp[4]}, 16'h0002);
    check("pair restart", 16'(pulses - n), 16'h0002);
    check("pair mode", protocol, codes[1]);
    foreach (codes[i])
    begin
      wr(`ADDR_PROTOCOL, codes[i]);
      wr(`ADDR_RESTART, `RESTART_KEY);
      check("mode", protocol, codes[i]);
    end
  endtask : t_protocol
  task automatic t_devid();
    byte_type ids[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h81, 8'h82, 8'h83};
    foreach (ids[i])
    begin
      xfer({`FC_DEVICE_ID, `MEI_DEVICE_ID, 8'h04, ids[i]});
      if (i == 8)
        check("bad obj", {rsp[0], rsp[1]}, 16'hab02);
      else
      begin
        check("obj", {rsp[3], rsp[7]}, {8'h83, ids[i]});
        for (int j = 0; j < 8; j++)
          check("obj text", 16'(rsp[9 + j]), 16'(ID_TEXT[i][63 - 8 * j -: 8]));
      end
    end
  endtask : t_devid
  task automatic t_function();
    byte_type fcs[3] = '{8'h01, 8'h04, 8'h06};
    foreach (fcs[i])
    begin
      xfer({fcs[i], 8'h00, 8'h00, 8'h00, 8'h01});
      check("bad fc", {rsp[0], rsp[1]}, {fcs[i] | 8'h80, 8'h01});
    end
    xfer({`FC_DEVICE_ID, 8'h0d, 8'h01, 8'h00});
    check("bad mei", {rsp[0], rsp[1]}, 16'hab01);
    xfer({`FC_READ_HOLDING, 8'hff, 8'hff, 8'h00, 8'h02});
    check("bad range", {rsp[0], rsp[1]}, 16'h8302);
    xfer({`FC_READ_HOLDING, 8'h00, 8'h00, 8'h00, 8'h00});
    check("zero qty", {rsp[0], rsp[1]}, 16'h8303);
    xfer({`FC_WRITE_MULTIPLE, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00});
    check("bad count", {rsp[0], rsp[1]}, 16'h9003);
    xfer({`FC_DEVICE_ID, `MEI_DEVICE_ID, 8'h00, 8'h00});
    check("bad code", {rsp[0], rsp[1]}, 16'hab03);
  endtask : t_function
  task automatic t_override();
    cmd_req = 1'b1;
    repeat (4) @(negedge clk_in);
    check("override", protocol, `PROTO_COMMAND_LINE);
    rd(`ADDR_PROTOCOL, 8'h01);
    check("ovr pend", w[0], `PROTO_COMMAND_LINE);
    cmd_req = 1'b0;
  endtask : t_override
  initial
  begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    check("reset mode", protocol, `PROTOCOL_RESET);
    t_consts();
    t_measure();
    t_protocol();
    master_u.slow = 1'b1;
    t_devid();
    t_function();
    t_override();
    give_verdict();
  end
endmodule : modbus_rtu_slave_register_map_tb_top
`default_nettype wire
